// ---- hw/scmn_pkg.sv ----
package scmn_pkg;
	localparam logic [7:0] SCMN_OFS_TX_SEED = 8'h14;
	localparam logic [7:0] SCMN_OFS_RX_SCR = 8'h18;
	localparam logic [7:0] SCMN_OFS_CFG = 8'h1c;
	localparam logic [7:0] SCMN_OFS_STATUS = 8'h20;
	localparam logic [7:0] SCMN_OFS_INT_STATUS = 8'h30;
	localparam logic [7:0] SCMN_OFS_INT_MASK = 8'h34;
	localparam logic [7:0] SCMN_OFS_NEG_CTRL = 8'h38;
	localparam int SCMN_SEED_W = 31;
	localparam int SCMN_RX_ACTIVE_BIT = 31;
	localparam int SCMN_HDLC_VALID_BIT = 11;
	localparam int SCMN_ETH_VALID_BIT = 6;
	localparam int SCMN_NEG_DONE_BIT = 0;
	localparam logic [30:0] SCMN_SEED_RESET = 31'h0;
	localparam logic [2:0] SCMN_HDLC_RATE_RESET = 3'h6;
	localparam logic [5:0] SCMN_ETH_PTR_RESET = 6'h14;
	localparam logic [5:0] SCMN_ETH_PTR_MIN = 6'h14;
	localparam logic [5:0] SCMN_ETH_PTR_MAX = 6'h3f;
	localparam logic [7:0] SCMN_PROT_VER_PLAIN = 8'h01;
	localparam logic [7:0] SCMN_PROT_VER_SCRAMBLED = 8'h02;
	localparam int SCMN_FILTER_HF = 5;
	localparam int SCMN_INT_W = 4;
	localparam int SCMN_INT_HDLC = 0;
	localparam int SCMN_INT_ETH = 1;
	localparam int SCMN_INT_SCR_CHANGE = 2;
	localparam int SCMN_INT_NEG_DONE = 3;
	localparam logic [1:0] SCMN_RESP_OKAY = 2'h0;
	localparam logic [1:0] SCMN_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic hdlc_autoneg;
		logic hdlc_filter;
		logic [2:0] hdlc_rate;
		logic eth_autoneg;
		logic eth_filter;
		logic [5:0] eth_ptr;
	} scmn_cfg_t;

	typedef struct packed {
		logic accepted;
		logic [5:0] value;
	} scmn_rx_field_t;
endpackage : scmn_pkg

// ---- hw/scmn_regs.sv ----
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
// How it works
// RULE_01 - writable 31-bit tx seed; zero sends unscrambled
// RULE_02 - bit 31 shows incoming scrambling from version
// RULE_03 - received seed readable, fed to descrambler
// RULE_04 - hdlc autoneg enable bit 12, resets 1
// RULE_05 - without negotiation option both autoneg bits zero
// RULE_06 - hdlc rate filter enable bit 11, resets 1
// RULE_07 - tx hdlc rate bits 10:8 into Z.66.0
// RULE_08 - ethernet autoneg enable bit 7, resets 1
// RULE_09 - ethernet pointer filter enable bit 6
// RULE_10 - tx ethernet pointer bits 5:0, into Z.194.0
// RULE_11 - status bit 11 flags accepted hdlc rate
// RULE_12 - status bits 10:8 hold accepted hdlc rate
// RULE_13 - status bit 6 flags accepted ethernet pointer
// RULE_14 - accepted pointer bits 5:0, only 0x14-0x3f
// RULE_15 - tx protocol version 1 plain, 2 scrambled
// RULE_16 - autoneg on marks management negotiation done itself
// RULE_17 - filtered values need repeated unchanged hyperframes
// RULE_18 - reserved bits read zero, writes ignored
module scmn_regs
	import scmn_pkg::*;
#(
	parameter bit NEGOTIATION_EN = 1'b1,
	parameter int FILTER_HF = SCMN_FILTER_HF
) (
	input wire logic CORE_CLK_IN,
	input wire logic NRST_IN,
	input wire logic [7:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic [7:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	input wire logic HYPERFRAME_STROBE_IN,
	input wire logic [7:0] RX_PROT_VER_IN,
	input wire logic RX_PROT_VER_VALID_IN,
	input wire logic [30:0] RX_SEED_IN,
	input wire logic RX_SEED_VALID_IN,
	input wire logic [7:0] RX_Z66_IN,
	input wire logic [7:0] RX_Z194_IN,
	input wire logic MGMT_SETUP_STATE_IN,
	output logic [30:0] TX_SEED_OUT,
	output logic [7:0] TX_PROT_VER_OUT,
	output logic [7:0] TX_Z66_OUT,
	output logic [7:0] TX_Z194_OUT,
	output logic [30:0] RX_SEED_OUT,
	output logic RX_SCRAMBLED_OUT,
	output logic MGMT_NEG_DONE_OUT,
	output logic IRQ_OUT
);

	function automatic logic [31:0] merge_strb(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = wdata[8*i +: 8];
			end
		end
		return res;
	endfunction : merge_strb

	function automatic logic [2:0] bump(input logic [2:0] cnt);
		return (cnt == 3'h7) ? cnt : cnt + 3'h1;
	endfunction : bump

	localparam logic [2:0] FILTER_N = 3'(FILTER_HF);

	scmn_cfg_t cfg;
	logic [30:0] tx_seed;
	logic [30:0] rx_seed;
	logic rx_scrambled;
	scmn_rx_field_t hdlc_rx;
	scmn_rx_field_t eth_rx;
	logic [2:0] hdlc_cand;
	logic [2:0] hdlc_cnt;
	logic [5:0] eth_cand;
	logic [2:0] eth_cnt;
	logic neg_done;
	logic [SCMN_INT_W-1:0] int_status;
	logic [SCMN_INT_W-1:0] int_mask;

	logic aw_full;
	logic w_full;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_take;
	logic w_take;
	logic do_write;
	logic ar_take;
	logic wr_hit;

	logic [2:0] next_hdlc_cnt;
	logic [2:0] next_eth_cnt;
	logic hdlc_sample_ok;
	logic eth_sample_ok;
	logic hdlc_accept;
	logic eth_accept;
	logic next_rx_scrambled;
	logic neg_auto_set;
	logic [SCMN_INT_W-1:0] int_events;
	logic [31:0] cfg_merged, seed_merged;

	// bus handshake: address and data held independently until both are in
	assign aw_take = S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT;
	assign w_take = S_AXI_WVALID_IN & S_AXI_WREADY_OUT;
	assign do_write = aw_full & w_full & ~S_AXI_BVALID_OUT;
	assign ar_take = S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT;

	always_comb begin
		unique case (aw_addr)
			SCMN_OFS_TX_SEED, SCMN_OFS_RX_SCR, SCMN_OFS_CFG,
			SCMN_OFS_STATUS, SCMN_OFS_INT_STATUS, SCMN_OFS_INT_MASK,
			SCMN_OFS_NEG_CTRL: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			aw_full <= 1'b0;
			aw_addr <= 8'h0;
			S_AXI_AWREADY_OUT <= 1'b1;
		end else if (do_write) begin
			aw_full <= 1'b0;
			S_AXI_AWREADY_OUT <= 1'b1;
		end else if (aw_take) begin
			aw_full <= 1'b1;
			aw_addr <= {S_AXI_AWADDR_IN[7:2], 2'h0};
			S_AXI_AWREADY_OUT <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			w_full <= 1'b0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			S_AXI_WREADY_OUT <= 1'b1;
		end else if (do_write) begin
			w_full <= 1'b0;
			S_AXI_WREADY_OUT <= 1'b1;
		end else if (w_take) begin
			w_full <= 1'b1;
			w_data <= S_AXI_WDATA_IN;
			w_strb <= S_AXI_WSTRB_IN;
			S_AXI_WREADY_OUT <= 1'b0;
		end
	end

	// read-only offsets accept writes with okay but change nothing
	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT <= SCMN_RESP_OKAY;
		end else if (do_write) begin
			S_AXI_BVALID_OUT <= 1'b1;
			S_AXI_BRESP_OUT <= wr_hit ? SCMN_RESP_OKAY : SCMN_RESP_SLVERR;
		end else if (S_AXI_BREADY_IN) begin
			S_AXI_BVALID_OUT <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			S_AXI_ARREADY_OUT <= 1'b1;
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT <= 32'h0;
			S_AXI_RRESP_OUT <= SCMN_RESP_OKAY;
		end else if (ar_take) begin
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT <= 1'b1;
			S_AXI_RRESP_OUT <= SCMN_RESP_OKAY;
			unique case ({S_AXI_ARADDR_IN[7:2], 2'h0})
				SCMN_OFS_TX_SEED: S_AXI_RDATA_OUT <= {1'b0, tx_seed}; // see RULE_18
				SCMN_OFS_RX_SCR: S_AXI_RDATA_OUT <= {rx_scrambled, rx_seed}; // see RULE_02
				SCMN_OFS_CFG: S_AXI_RDATA_OUT <= {19'h0, cfg};
				SCMN_OFS_STATUS: S_AXI_RDATA_OUT <= {20'h0, hdlc_rx.accepted,
					hdlc_rx.value[2:0], 1'b0, eth_rx.accepted,
					eth_rx.value}; // see RULE_11
				SCMN_OFS_INT_STATUS: S_AXI_RDATA_OUT <= {28'h0, int_status};
				SCMN_OFS_INT_MASK: S_AXI_RDATA_OUT <= {28'h0, int_mask};
				SCMN_OFS_NEG_CTRL: S_AXI_RDATA_OUT <= {31'h0, neg_done};
				default: begin
					S_AXI_RDATA_OUT <= 32'h0;
					S_AXI_RRESP_OUT <= SCMN_RESP_SLVERR;
				end
			endcase
		end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
			S_AXI_ARREADY_OUT <= 1'b1;
			S_AXI_RVALID_OUT <= 1'b0;
		end
	end

	assign cfg_merged = merge_strb({19'h0, cfg}, w_data, w_strb);
	assign seed_merged = merge_strb({1'b0, tx_seed}, w_data, w_strb);

	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			tx_seed <= SCMN_SEED_RESET; // see RULE_01
		end else if (do_write && aw_addr == SCMN_OFS_TX_SEED) begin
			tx_seed <= seed_merged[30:0];
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			cfg.hdlc_autoneg <= NEGOTIATION_EN; // see RULE_04
			cfg.hdlc_filter <= 1'b1; // see RULE_06
			cfg.hdlc_rate <= SCMN_HDLC_RATE_RESET; // see RULE_07
			cfg.eth_autoneg <= NEGOTIATION_EN; // see RULE_08
			cfg.eth_filter <= 1'b1; // see RULE_09
			cfg.eth_ptr <= SCMN_ETH_PTR_RESET; // see RULE_10
		end else if (do_write && aw_addr == SCMN_OFS_CFG) begin
			// autoneg bits stay zero when negotiation is not built in
			cfg.hdlc_autoneg <= cfg_merged[12] & NEGOTIATION_EN; // see RULE_05
			cfg.hdlc_filter <= cfg_merged[11];
			cfg.hdlc_rate <= cfg_merged[10:8];
			cfg.eth_autoneg <= cfg_merged[7] & NEGOTIATION_EN; // see RULE_05
			cfg.eth_filter <= cfg_merged[6];
			cfg.eth_ptr <= cfg_merged[5:0];
		end
	end

	// link-side values; version byte is one cycle behind the seed write
	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			TX_PROT_VER_OUT <= SCMN_PROT_VER_PLAIN;
			TX_Z66_OUT <= 8'h0;
			TX_Z194_OUT <= 8'h0;
		end else begin
			TX_PROT_VER_OUT <= (tx_seed == SCMN_SEED_RESET) ?
				SCMN_PROT_VER_PLAIN : SCMN_PROT_VER_SCRAMBLED; // see RULE_15
			TX_Z66_OUT <= {5'h0, cfg.hdlc_rate}; // see RULE_07
			TX_Z194_OUT <= {2'h0, cfg.eth_ptr}; // see RULE_10
		end
	end

	assign TX_SEED_OUT = tx_seed; // see RULE_01
	assign RX_SEED_OUT = rx_seed; // see RULE_03
	assign RX_SCRAMBLED_OUT = rx_scrambled;

	assign next_rx_scrambled = RX_PROT_VER_VALID_IN ?
		(RX_PROT_VER_IN == SCMN_PROT_VER_SCRAMBLED) : rx_scrambled;

	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			rx_scrambled <= 1'b0;
			rx_seed <= SCMN_SEED_RESET;
		end else begin
			rx_scrambled <= next_rx_scrambled; // see RULE_02
			if (RX_SEED_VALID_IN) begin
				rx_seed <= RX_SEED_IN; // see RULE_03
			end
		end
	end

	// a rate of zero means no hdlc channel, so it is never accepted
	assign hdlc_sample_ok = RX_Z66_IN[2:0] != 3'h0;
	assign eth_sample_ok = RX_Z194_IN[5:0] >= SCMN_ETH_PTR_MIN &&
		RX_Z194_IN[5:0] <= SCMN_ETH_PTR_MAX; // see RULE_14
	assign next_hdlc_cnt = (RX_Z66_IN[2:0] == hdlc_cand) ?
		bump(hdlc_cnt) : 3'h1;
	assign next_eth_cnt = (RX_Z194_IN[5:0] == eth_cand) ?
		bump(eth_cnt) : 3'h1;
	// filtering trades acceptance latency for immunity to single bit errors
	assign hdlc_accept = HYPERFRAME_STROBE_IN & hdlc_sample_ok &
		(~cfg.hdlc_filter | next_hdlc_cnt >= FILTER_N); // see RULE_17
	assign eth_accept = HYPERFRAME_STROBE_IN & eth_sample_ok &
		(~cfg.eth_filter | next_eth_cnt >= FILTER_N); // see RULE_17

	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			hdlc_cand <= 3'h0;
			hdlc_cnt <= 3'h0;
			hdlc_rx <= '0;
		end else if (HYPERFRAME_STROBE_IN) begin
			hdlc_cand <= RX_Z66_IN[2:0];
			hdlc_cnt <= next_hdlc_cnt;
			if (hdlc_accept) begin
				hdlc_rx.accepted <= 1'b1; // see RULE_11
				hdlc_rx.value <= {3'h0, RX_Z66_IN[2:0]}; // see RULE_12
			end
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			eth_cand <= 6'h0;
			eth_cnt <= 3'h0;
			eth_rx <= '0;
		end else if (HYPERFRAME_STROBE_IN) begin
			eth_cand <= RX_Z194_IN[5:0];
			eth_cnt <= next_eth_cnt;
			if (eth_accept) begin
				eth_rx.accepted <= 1'b1; // see RULE_13
				eth_rx.value <= RX_Z194_IN[5:0]; // see RULE_14
			end
		end
	end

	assign neg_auto_set = MGMT_SETUP_STATE_IN &
		(cfg.hdlc_autoneg | cfg.eth_autoneg) &
		(~cfg.hdlc_autoneg | hdlc_rx.accepted) &
		(~cfg.eth_autoneg | eth_rx.accepted);

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			neg_done <= 1'b0;
		end else if (neg_auto_set) begin
			neg_done <= 1'b1; // see RULE_16
		end else if (do_write && aw_addr == SCMN_OFS_NEG_CTRL && w_strb[0]) begin
			neg_done <= w_data[SCMN_NEG_DONE_BIT];
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			MGMT_NEG_DONE_OUT <= 1'b0;
		end else begin
			MGMT_NEG_DONE_OUT <= neg_done;
		end
	end

	always_comb begin
		int_events = '0;
		int_events[SCMN_INT_HDLC] = hdlc_accept;
		int_events[SCMN_INT_ETH] = eth_accept;
		int_events[SCMN_INT_SCR_CHANGE] = next_rx_scrambled ^ rx_scrambled;
		int_events[SCMN_INT_NEG_DONE] = neg_auto_set & ~neg_done;
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			int_status <= '0;
			int_mask <= '0;
		end else begin
			if (do_write && aw_addr == SCMN_OFS_INT_STATUS && w_strb[0]) begin
				int_status <= (int_status & ~w_data[SCMN_INT_W-1:0]) |
					int_events;
			end else begin
				int_status <= int_status | int_events;
			end
			if (do_write && aw_addr == SCMN_OFS_INT_MASK && w_strb[0]) begin
				int_mask <= w_data[SCMN_INT_W-1:0];
			end
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= |(int_status & int_mask);
		end
	end

endmodule : scmn_regs

// ---- dv/scmn_link_partner.sv ----
`timescale 1ns/1ns
module scmn_link_partner (
	input wire logic clk_in,
	output logic hf_out,
	output logic [7:0] z66_out,
	output logic [7:0] z194_out,
	output logic [7:0] ver_out,
	output logic vv_out,
	output logic [30:0] seed_out,
	output logic sv_out
);
	initial {hf_out, z66_out, z194_out, ver_out} = '0;
	initial {vv_out, seed_out, sv_out} = '0;
	// bytes count only at the strobe, so they are inverted between frames
	task automatic frame(input logic [7:0] a, input logic [7:0] b);
		hf_out <= 1'b1;
		z66_out <= a;
		z194_out <= b;
		@(posedge clk_in);
		hf_out <= 1'b0;
		z66_out <= ~a;
		z194_out <= ~b;
		@(posedge clk_in);
	endtask : frame
	task automatic prot(input logic [7:0] v, input logic [30:0] s);
		ver_out <= v;
		seed_out <= s;
		vv_out <= 1'b1;
		sv_out <= 1'b1;
		@(posedge clk_in);
		vv_out <= 1'b0;
		sv_out <= 1'b0;
		ver_out <= ~v;
		seed_out <= ~s;
		@(posedge clk_in);
	endtask : prot
endmodule : scmn_link_partner

// ---- dv/scmn_regs_chk.sv ----
`timescale 1ns/1ns
module scmn_regs_chk (
	input wire logic CORE_CLK_IN,
	input wire logic NRST_IN,
	input wire logic [30:0] TX_SEED_OUT,
	input wire logic [7:0] TX_PROT_VER_OUT,
	input wire logic [7:0] TX_Z66_OUT,
	input wire logic [7:0] TX_Z194_OUT,
	input wire logic [7:0] RX_PROT_VER_IN,
	input wire logic RX_PROT_VER_VALID_IN,
	input wire logic RX_SCRAMBLED_OUT,
	input wire logic [30:0] RX_SEED_IN,
	input wire logic RX_SEED_VALID_IN,
	input wire logic [30:0] RX_SEED_OUT
);
	default clocking @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!NRST_IN);
	// outputs are registered, so each relation lands one edge later
	a_ver_plain: assert property (
		TX_SEED_OUT == 31'h0 |=> TX_PROT_VER_OUT == 8'h01)
		else $error("plain version missing");
	a_ver_scrambled: assert property (
		TX_SEED_OUT != 31'h0 |=> TX_PROT_VER_OUT == 8'h02)
		else $error("scrambled version missing");
	a_rx_scr_flag: assert property (
		RX_PROT_VER_VALID_IN
		|=> RX_SCRAMBLED_OUT == ($past(RX_PROT_VER_IN) == 8'h02))
		else $error("scrambled flag wrong");
	a_rx_scr_hold: assert property (
		!RX_PROT_VER_VALID_IN |=> $stable(RX_SCRAMBLED_OUT))
		else $error("scrambled flag moved");
	a_rx_seed_take: assert property (
		RX_SEED_VALID_IN |=> RX_SEED_OUT == $past(RX_SEED_IN))
		else $error("received seed not taken");
	a_rx_seed_hold: assert property (
		!RX_SEED_VALID_IN |=> $stable(RX_SEED_OUT))
		else $error("received seed moved");
	a_z66_pad: assert property (
		TX_Z66_OUT[7:3] == 5'h0) else $error("rate byte pad");
	a_z194_pad: assert property (
		TX_Z194_OUT[7:6] == 2'h0) else $error("pointer byte pad");
endmodule : scmn_regs_chk
bind scmn_regs scmn_regs_chk scmn_regs_chk_inst (
	.CORE_CLK_IN(CORE_CLK_IN), .NRST_IN(NRST_IN),
	.TX_SEED_OUT(TX_SEED_OUT), .TX_PROT_VER_OUT(TX_PROT_VER_OUT),
	.TX_Z66_OUT(TX_Z66_OUT), .TX_Z194_OUT(TX_Z194_OUT),
	.RX_PROT_VER_IN(RX_PROT_VER_IN),
	.RX_PROT_VER_VALID_IN(RX_PROT_VER_VALID_IN),
	.RX_SCRAMBLED_OUT(RX_SCRAMBLED_OUT), .RX_SEED_IN(RX_SEED_IN),
	.RX_SEED_VALID_IN(RX_SEED_VALID_IN), .RX_SEED_OUT(RX_SEED_OUT));

// ---- dv/testbench.sv ----
`timescale 1ns/1ns
module testbench;
	import scmn_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic setup = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, hf, vv, sv, done;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] z66, z194, ver, tver, tz66, tz194;
	logic [30:0] seed, tseed, s;
	logic [33:0] q[$];
	logic [33:0] e;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	scmn_regs #(.NEGOTIATION_EN(1'b1), .FILTER_HF(5)) scmn_regs_inst (
		.CORE_CLK_IN(clk), .NRST_IN(rst_n), .S_AXI_AWADDR_IN(awaddr),
		.S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf),
		.S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
		.S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
		.S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
		.S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
		.HYPERFRAME_STROBE_IN(hf), .RX_PROT_VER_IN(ver),
		.RX_PROT_VER_VALID_IN(vv), .RX_SEED_IN(seed),
		.RX_SEED_VALID_IN(sv), .RX_Z66_IN(z66), .RX_Z194_IN(z194),
		.MGMT_SETUP_STATE_IN(setup), .TX_SEED_OUT(tseed),
		.TX_PROT_VER_OUT(tver), .TX_Z66_OUT(tz66), .TX_Z194_OUT(tz194),
		.RX_SEED_OUT(), .RX_SCRAMBLED_OUT(), .MGMT_NEG_DONE_OUT(done),
		.IRQ_OUT(irq));
	scmn_link_partner scmn_link_partner_inst (.clk_in(clk), .hf_out(hf),
		.z66_out(z66), .z194_out(z194), .ver_out(ver), .vv_out(vv),
		.seed_out(seed), .sv_out(sv));
	initial forever #5 clk = ~clk;
	task automatic conclude();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			num_errors++;
			$display("FAIL %0t got %h want %h", $time, g, x);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		q.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (!ad && awready) begin
				awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (!wd && wready) begin
				wvalid <= 1'b0;
				wd = 1'b1;
			end
		end
		bready <= 1'b1;
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		q.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask : rd
	// one bus transfer at a time, so one queue serves both directions
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			$display("FAIL %0t timeout", $time);
			conclude();
		end else if ((bvalid && bready) || (rvalid && rready)) begin
			e = q.pop_front();
			chk(32'(bvalid ? bresp : rresp), 32'(e[33:32]));
			if (rvalid) begin
				chk(rdata, e[31:0]);
			end
		end
	end
	initial begin
		void'($urandom(35666));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(SCMN_OFS_TX_SEED, 32'h0, SCMN_RESP_OKAY);
		rd(SCMN_OFS_RX_SCR, 32'h0, SCMN_RESP_OKAY);
		rd(SCMN_OFS_CFG, 32'h1ed4, SCMN_RESP_OKAY);
		rd(SCMN_OFS_STATUS, 32'h0, SCMN_RESP_OKAY);
		$display("test reset done");
		s = 31'($urandom()) | 31'h1;
		wr(SCMN_OFS_TX_SEED, {1'b1, s}, SCMN_RESP_OKAY);
		rd(SCMN_OFS_TX_SEED, {1'b0, s}, SCMN_RESP_OKAY);
		chk({1'b0, tseed}, {1'b0, s});
		chk(32'(tver), 32'(SCMN_PROT_VER_SCRAMBLED));
		wr(SCMN_OFS_TX_SEED, 32'h0, SCMN_RESP_OKAY);
		repeat (2) @(posedge clk);
		chk(32'(tver), 32'(SCMN_PROT_VER_PLAIN));
		$display("test seed done");
		wr(SCMN_OFS_CFG, 32'hffffffff, SCMN_RESP_OKAY);
		rd(SCMN_OFS_CFG, 32'h1fff, SCMN_RESP_OKAY);
		chk(32'({tz194, tz66}), 32'h3f07);
		wr(SCMN_OFS_CFG, 32'h1ed4, SCMN_RESP_OKAY);
		wr(SCMN_OFS_STATUS, 32'hffffffff, SCMN_RESP_OKAY);
		rd(SCMN_OFS_STATUS, 32'h0, SCMN_RESP_OKAY);
		wr(8'h40, 32'h1, SCMN_RESP_SLVERR);
		rd(8'h40, 32'h0, SCMN_RESP_SLVERR);
		$display("test config done");
		s = 31'($urandom());
		scmn_link_partner_inst.prot(SCMN_PROT_VER_SCRAMBLED, s);
		rd(SCMN_OFS_RX_SCR, {1'b1, s}, SCMN_RESP_OKAY);
		scmn_link_partner_inst.prot(SCMN_PROT_VER_PLAIN, s);
		rd(SCMN_OFS_RX_SCR, {1'b0, s}, SCMN_RESP_OKAY);
		chk(32'(irq), 32'h0);
		wr(SCMN_OFS_INT_MASK, 32'hf, SCMN_RESP_OKAY);
		@(posedge clk);
		chk(32'(irq), 32'h1);
		wr(SCMN_OFS_INT_STATUS, 32'hf, SCMN_RESP_OKAY);
		@(posedge clk);
		chk(32'(irq), 32'h0);
		rd(SCMN_OFS_INT_STATUS, 32'h0, SCMN_RESP_OKAY);
		$display("test link done");
		repeat (4) scmn_link_partner_inst.frame(8'h03, 8'h13);
		rd(SCMN_OFS_STATUS, 32'h0, SCMN_RESP_OKAY);
		scmn_link_partner_inst.frame(8'h03, 8'h13);
		rd(SCMN_OFS_STATUS, 32'hb00, SCMN_RESP_OKAY);
		chk(32'(irq), 32'h1);
		repeat (5) scmn_link_partner_inst.frame(8'h00, 8'h3f);
		rd(SCMN_OFS_STATUS, 32'hb7f, SCMN_RESP_OKAY);
		wr(SCMN_OFS_CFG, 32'h1694, SCMN_RESP_OKAY);
		scmn_link_partner_inst.frame(8'h05, 8'h20);
		rd(SCMN_OFS_STATUS, 32'hd60, SCMN_RESP_OKAY);
		$display("test filter done");
		setup <= 1'b1;
		repeat (3) @(posedge clk);
		rd(SCMN_OFS_NEG_CTRL, 32'h1, SCMN_RESP_OKAY);
		chk(32'(done), 32'h1);
		$display("test negotiation done");
		conclude();
	end
endmodule : testbench
